// [rtl/rca_regs.vh]
// Constants for the small 8-bit core: widths, encodings, SFR map, resets
// Function
// [RQ1] Program words and data bytes move on separate ports in one cycle.
// [RQ2] Every instruction is one 14-bit word in one program location.
// [RQ3] The program port delivers one whole 14-bit word each cycle.
// [RQ4] The next word is fetched while the current one executes.
// [RQ5] Instructions take one cycle; flow changes drop the prefetch.
// [RQ6] Special registers, the program counter too, sit in data space.
// [RQ7] Data registers are reached directly or through a pointer.
// [RQ8] The ALU adds, subtracts, shifts and does logic on 8-bit data.
// [RQ9] Arithmetic is two's complement unless an instruction says not.
// [RQ10] Two-operand work takes the accumulator and a file or literal.
// [RQ11] Single-operand work takes the accumulator or a file register.
// [RQ12] The accumulator is 8 bits wide and has no data address.
// [RQ13] Carry, nibble carry and zero flags update per instruction.
// [RQ14] In subtraction carry and nibble carry report no-borrow.
// [RQ15] File-operand results go to accumulator or file as selected.
`ifndef RCA_REGS_VH
`define RCA_REGS_VH

`define RCA_IW 14
`define RCA_DW 8
`define RCA_PCW 13
`define RCA_AW 8
`define RCA_STK_D 8
`define RCA_STK_AW 3

`define RCA_CL_FILE 2'h0
`define RCA_CL_BIT 2'h1
`define RCA_CL_JUMP 2'h2
`define RCA_CL_LIT 2'h3

`define RCA_F_MISC 4'h0
`define RCA_F_CLR 4'h1
`define RCA_F_SUB 4'h2
`define RCA_F_DEC 4'h3
`define RCA_F_IOR 4'h4
`define RCA_F_AND 4'h5
`define RCA_F_XOR 4'h6
`define RCA_F_ADD 4'h7
`define RCA_F_MOV 4'h8
`define RCA_F_COM 4'h9
`define RCA_F_INC 4'hA
`define RCA_F_DECSZ 4'hB
`define RCA_F_RRC 4'hC
`define RCA_F_RLC 4'hD
`define RCA_F_SWAP 4'hE
`define RCA_F_INCSZ 4'hF
`define RCA_MISC_RET 7'h08

`define RCA_B_CLR 2'h0
`define RCA_B_SET 2'h1
`define RCA_B_SKC 2'h2
`define RCA_B_SKS 2'h3

`define RCA_L_MOV 4'h0
`define RCA_L_RET 4'h1
`define RCA_L_IOR 4'h2
`define RCA_L_AND 4'h3
`define RCA_L_XOR 4'h4
`define RCA_L_SUB 4'h5
`define RCA_L_ADD 4'h6

`define RCA_ALU_ADD 4'h0
`define RCA_ALU_SUB 4'h1
`define RCA_ALU_AND 4'h2
`define RCA_ALU_IOR 4'h3
`define RCA_ALU_XOR 4'h4
`define RCA_ALU_COM 4'h5
`define RCA_ALU_INC 4'h6
`define RCA_ALU_DEC 4'h7
`define RCA_ALU_RRC 4'h8
`define RCA_ALU_RLC 4'h9
`define RCA_ALU_SWAP 4'hA
`define RCA_ALU_PASSB 4'hB
`define RCA_ALU_PASSA 4'hC
`define RCA_ALU_ZERO 4'hD

`define RCA_A_INDF 7'h00
`define RCA_A_PCL 7'h02
`define RCA_A_STATUS 7'h03
`define RCA_A_FSR 7'h04

`define RCA_ST_C 0
`define RCA_ST_NC 1
`define RCA_ST_Z 2
`define RCA_ST_RP0 5

`define RCA_ST_RST 8'h00
`define RCA_FSR_RST 8'h00
`define RCA_ACC_RST 8'h00
`define RCA_PC_RST 13'h0000

`endif

// [rtl/rca_alu.v]
// Eight-bit arithmetic and logic unit of the core
`timescale 1ns/1ps
`include "rca_regs.vh"
module rca_alu (
	input wire [7:0] acc_in,
	input wire [7:0] opd_in,
	input wire [3:0] op,
	input wire carry_in,
	output reg [7:0] result,
	output reg carry_out,
	output reg nibble_carry_out,
	output wire zero_out
);
reg [7:0] addend;
reg [8:0] sum;
reg [4:0] nib;
reg sub_sel;

always @*
begin
	// [RQ9] Two's complement subtract
	sub_sel = (op == `RCA_ALU_SUB);
	addend = sub_sel ? ~acc_in : acc_in;
	sum = {1'b0, opd_in} + {1'b0, addend} + {8'h00, sub_sel};
	nib = {1'b0, opd_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_sel};
	result = opd_in;
	carry_out = carry_in;
	nibble_carry_out = 1'b0;
	// [RQ8] Operation select
	case (op)
		`RCA_ALU_ADD, `RCA_ALU_SUB:
		begin
			// [RQ14] Carry out means no borrow
			result = sum[7:0];
			carry_out = sum[8];
			nibble_carry_out = nib[4];
		end
		`RCA_ALU_AND: result = opd_in & acc_in;
		`RCA_ALU_IOR: result = opd_in | acc_in;
		`RCA_ALU_XOR: result = opd_in ^ acc_in;
		`RCA_ALU_COM: result = ~opd_in;
		`RCA_ALU_INC: result = opd_in + 8'h01;
		`RCA_ALU_DEC: result = opd_in - 8'h01;
		`RCA_ALU_RRC:
		begin
			result = {carry_in, opd_in[7:1]};
			carry_out = opd_in[0];
		end
		`RCA_ALU_RLC:
		begin
			result = {opd_in[6:0], carry_in};
			carry_out = opd_in[7];
		end
		`RCA_ALU_SWAP: result = {opd_in[3:0], opd_in[7:4]};
		`RCA_ALU_PASSA: result = acc_in;
		`RCA_ALU_ZERO: result = 8'h00;
		default: result = opd_in;
	endcase
end

assign zero_out = (result == 8'h00);
endmodule // rca_alu

// [rtl/rca_core.v]
// Two-stage fetch/execute datapath of the small 8-bit core
`timescale 1ns/1ps
`include "rca_regs.vh"
module rca_core (
	input wire clk_sys,
	input wire rst,
	input wire [13:0] prog_data,
	output wire [12:0] prog_addr,
	input wire [7:0] dm_rdata,
	output wire [7:0] dm_raddr,
	output wire [7:0] dm_waddr,
	output wire [7:0] dm_wdata,
	output wire dm_we,
	output wire [7:0] acc_out,
	output wire [7:0] status_out
);
reg [12:0] prog_addr_reg;
reg [13:0] ir_reg;
reg ir_valid_reg;
reg [7:0] acc_reg;
reg [7:0] status_reg;
reg [7:0] fsr_reg;
reg [7:0] dm_raddr_reg;
reg [7:0] dm_waddr_reg;
reg [7:0] dm_wdata_reg;
reg dm_we_reg;
reg [2:0] sp_reg;
reg [12:0] stk [0:7];

reg [3:0] alu_op;
reg [7:0] alu_b;
wire [7:0] alu_y;
wire alu_c;
wire alu_nc;
wire alu_z;

reg [7:0] opnd;
reg [7:0] res;
reg acc_wr;
reg file_wr;
reg upd_z;
reg upd_cdc;
reg upd_c;
reg skip;
reg jump;
reg push;
reg pop;
reg [12:0] target;
reg [7:0] status_next;
reg [7:0] fsr_next;

wire [1:0] cls;
wire [3:0] fop;
wire dbit;
wire [6:0] f7;
wire [1:0] bop;
wire [2:0] bnum;
wire [7:0] kval;
wire [6:0] a7;
wire [2:0] sp_top;

// Decode of SFRs kept inside the core
function is_int;
	input [6:0] a;
	begin
		is_int = (a == `RCA_A_INDF) || (a == `RCA_A_PCL) ||
			(a == `RCA_A_STATUS) || (a == `RCA_A_FSR);
	end
endfunction

// Direct uses bank bit and field; pointer slot goes through FSR
function [7:0] dm_decode;
	input [6:0] f;
	input [7:0] fsr;
	input rp0;
	begin
		if (f == `RCA_A_INDF)
			dm_decode = fsr;
		else
			dm_decode = {rp0, f};
	end
endfunction

// [RQ2] Single-word fields
assign cls = ir_reg[13:12];
assign fop = ir_reg[11:8];
assign dbit = ir_reg[7];
assign f7 = ir_reg[6:0];
assign bop = ir_reg[11:10];
assign bnum = ir_reg[9:7];
assign kval = ir_reg[7:0];
assign a7 = dm_raddr_reg[6:0];
assign sp_top = sp_reg - 3'h1;

// [RQ6] SFRs and PC read in data space
always @*
begin
	if (a7 == `RCA_A_INDF)
		opnd = 8'h00;
	else if (a7 == `RCA_A_PCL)
		opnd = prog_addr_reg[7:0];
	else if (a7 == `RCA_A_STATUS)
		opnd = status_reg;
	else if (a7 == `RCA_A_FSR)
		opnd = fsr_reg;
	else if (dm_we_reg && (dm_waddr_reg == dm_raddr_reg))
		opnd = dm_wdata_reg;
	else
		opnd = dm_rdata;
end

// [RQ10] Second source: file or literal
always @*
begin
	alu_b = (cls == `RCA_CL_LIT) ? kval : opnd;
	alu_op = `RCA_ALU_PASSB;
	if (cls == `RCA_CL_FILE)
	begin
		// [RQ11] Single operand from file or acc
		case (fop)
			`RCA_F_MISC: alu_op = `RCA_ALU_PASSA;
			`RCA_F_CLR: alu_op = `RCA_ALU_ZERO;
			`RCA_F_SUB: alu_op = `RCA_ALU_SUB;
			`RCA_F_DEC, `RCA_F_DECSZ: alu_op = `RCA_ALU_DEC;
			`RCA_F_IOR: alu_op = `RCA_ALU_IOR;
			`RCA_F_AND: alu_op = `RCA_ALU_AND;
			`RCA_F_XOR: alu_op = `RCA_ALU_XOR;
			`RCA_F_ADD: alu_op = `RCA_ALU_ADD;
			`RCA_F_COM: alu_op = `RCA_ALU_COM;
			`RCA_F_INC, `RCA_F_INCSZ: alu_op = `RCA_ALU_INC;
			`RCA_F_RRC: alu_op = `RCA_ALU_RRC;
			`RCA_F_RLC: alu_op = `RCA_ALU_RLC;
			`RCA_F_SWAP: alu_op = `RCA_ALU_SWAP;
			default: alu_op = `RCA_ALU_PASSB;
		endcase
	end
	else if (cls == `RCA_CL_LIT)
	begin
		case (fop)
			`RCA_L_IOR: alu_op = `RCA_ALU_IOR;
			`RCA_L_AND: alu_op = `RCA_ALU_AND;
			`RCA_L_XOR: alu_op = `RCA_ALU_XOR;
			`RCA_L_SUB: alu_op = `RCA_ALU_SUB;
			`RCA_L_ADD: alu_op = `RCA_ALU_ADD;
			default: alu_op = `RCA_ALU_PASSB;
		endcase
	end
end

// [RQ8] Shared ALU
rca_alu u_alu (
	.acc_in(acc_reg),
	.opd_in(alu_b),
	.op(alu_op),
	.carry_in(status_reg[`RCA_ST_C]),
	.result(alu_y),
	.carry_out(alu_c),
	.nibble_carry_out(alu_nc),
	.zero_out(alu_z)
);

always @*
begin
	res = alu_y;
	acc_wr = 1'b0;
	file_wr = 1'b0;
	upd_z = 1'b0;
	upd_cdc = 1'b0;
	upd_c = 1'b0;
	skip = 1'b0;
	jump = 1'b0;
	push = 1'b0;
	pop = 1'b0;
	target = prog_addr_reg;
	if (ir_valid_reg)
	begin
		case (cls)
			`RCA_CL_FILE:
			begin
				// [RQ15] Destination bit picks acc or file
				acc_wr = ~dbit;
				file_wr = dbit;
				case (fop)
					`RCA_F_MISC:
					begin
						acc_wr = 1'b0;
						if (!dbit && f7 == `RCA_MISC_RET)
						begin
							jump = 1'b1;
							pop = 1'b1;
							target = stk[sp_top];
						end
					end
					// [RQ13] Flag update per op
					`RCA_F_SUB, `RCA_F_ADD:
					begin
						upd_z = 1'b1;
						upd_cdc = 1'b1;
					end
					`RCA_F_RRC, `RCA_F_RLC: upd_c = 1'b1;
					`RCA_F_SWAP: upd_z = 1'b0;
					`RCA_F_DECSZ, `RCA_F_INCSZ: skip = alu_z;
					default: upd_z = 1'b1;
				endcase
			end
			`RCA_CL_BIT:
			begin
				case (bop)
					`RCA_B_CLR:
					begin
						res = opnd & ~(8'h01 << bnum);
						file_wr = 1'b1;
					end
					`RCA_B_SET:
					begin
						res = opnd | (8'h01 << bnum);
						file_wr = 1'b1;
					end
					`RCA_B_SKC: skip = ~opnd[bnum];
					default: skip = opnd[bnum];
				endcase
			end
			`RCA_CL_JUMP:
			begin
				jump = 1'b1;
				push = ~ir_reg[11];
				target = {prog_addr_reg[12:11], ir_reg[10:0]};
			end
			default:
			begin
				acc_wr = 1'b1;
				if (fop == `RCA_L_RET)
				begin
					jump = 1'b1;
					pop = 1'b1;
					target = stk[sp_top];
				end
				else if (fop == `RCA_L_SUB || fop == `RCA_L_ADD)
				begin
					upd_z = 1'b1;
					upd_cdc = 1'b1;
				end
				else if (fop != `RCA_L_MOV)
					upd_z = 1'b1;
			end
		endcase
		// [RQ6] Writing PCL redirects the fetch
		if (file_wr && a7 == `RCA_A_PCL)
		begin
			jump = 1'b1;
			target = {prog_addr_reg[12:8], res};
		end
	end
end

// Flags land after a file write so arithmetic wins on STATUS
always @*
begin
	status_next = status_reg;
	fsr_next = fsr_reg;
	if (file_wr && a7 == `RCA_A_STATUS)
		status_next = res;
	if (file_wr && a7 == `RCA_A_FSR)
		fsr_next = res;
	// [RQ14] Borrow report from ALU carry
	if (upd_cdc)
	begin
		status_next[`RCA_ST_C] = alu_c;
		status_next[`RCA_ST_NC] = alu_nc;
	end
	if (upd_c)
		status_next[`RCA_ST_C] = alu_c;
	if (upd_z)
		status_next[`RCA_ST_Z] = alu_z;
end

always @(posedge clk_sys)
begin
	if (rst)
	begin
		prog_addr_reg <= `RCA_PC_RST;
		ir_reg <= 14'h0000;
		ir_valid_reg <= 1'b0;
		acc_reg <= `RCA_ACC_RST;
		status_reg <= `RCA_ST_RST;
		fsr_reg <= `RCA_FSR_RST;
		dm_raddr_reg <= 8'h00;
		dm_waddr_reg <= 8'h00;
		dm_wdata_reg <= 8'h00;
		dm_we_reg <= 1'b0;
		sp_reg <= 3'h0;
	end
	else
	begin
		// [RQ4] Fetch overlaps execute
		// [RQ3] One word per cycle
		ir_reg <= prog_data;
		prog_addr_reg <= jump ? target : prog_addr_reg + 13'h0001;
		// [RQ5] Flow change drops prefetch
		ir_valid_reg <= ~(jump | skip);
		// [RQ7] Direct or pointer address
		dm_raddr_reg <= dm_decode(prog_data[6:0], fsr_next,
			status_next[`RCA_ST_RP0]);
		// [RQ1] Data write on its own port
		dm_we_reg <= file_wr && !is_int(a7);
		dm_waddr_reg <= dm_raddr_reg;
		dm_wdata_reg <= res;
		// [RQ12] Accumulator only via operands
		if (acc_wr)
			acc_reg <= res;
		status_reg <= status_next;
		fsr_reg <= fsr_next;
		if (push)
			sp_reg <= sp_reg + 3'h1;
		else if (pop)
			sp_reg <= sp_top;
	end
end

// Stack wraps silently; no overflow flag
always @(posedge clk_sys)
begin
	if (!rst && push)
		stk[sp_reg] <= prog_addr_reg;
end

assign prog_addr = prog_addr_reg;
assign dm_raddr = dm_raddr_reg;
assign dm_waddr = dm_waddr_reg;
assign dm_wdata = dm_wdata_reg;
assign dm_we = dm_we_reg;
assign acc_out = acc_reg;
assign status_out = status_reg;
endmodule // rca_core

// [tb/rca_core_properties.sv]
// Port checks for the core
`timescale 1ns/1ps
`include "rca_regs.vh"
module rca_core_properties (
	input wire clk_sys,
	input wire rst,
	input wire [13:0] prog_data,
	input wire [12:0] prog_addr,
	input wire [7:0] dm_rdata,
	input wire [7:0] dm_raddr,
	input wire [7:0] dm_waddr,
	input wire [7:0] dm_wdata,
	input wire dm_we,
	input wire [7:0] acc_out,
	input wire [7:0] status_out
);
	wire [1:0] cls = prog_data[13:12];
	wire [3:0] sub = prog_data[11:8];
	wire [7:0] k = prog_data[7:0];
	wire [6:0] fa = prog_data[6:0];
	wire [3:0] k_lo = prog_data[3:0];
	wire [3:0] a_lo = acc_out[3:0];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Earlier word is a plain literal, so this one is not dropped
	sequence s_ok;
		$past(cls) == `RCA_CL_LIT && $past(sub) != `RCA_L_RET;
	endsequence
	sequence s_lit(logic [3:0] op);
		s_ok ##0 (cls == `RCA_CL_LIT && sub == op);
	endsequence
	a_reset_state: assert property (
		$fell(rst) |-> prog_addr == 13'h0000 && !dm_we &&
		acc_out == 8'h00 && status_out == 8'h00)
		else $error("reset state wrong");
	a_pc_step: assert property (
		s_ok ##0 (cls == `RCA_CL_LIT && sub != `RCA_L_RET) |=> ##1
		prog_addr == $past(prog_addr) + 13'h0001)
		else $error("fetch address did not step");
	a_add_sum: assert property (
		s_lit(`RCA_L_ADD) |=> ##1 {status_out[`RCA_ST_C], acc_out} ==
		{1'b0, $past(acc_out)} + {1'b0, $past(k, 2)})
		else $error("add result or carry wrong");
	a_add_nibble: assert property (
		s_lit(`RCA_L_ADD) |=> ##1 status_out[`RCA_ST_NC] ==
		({1'b0, $past(a_lo)} + {1'b0, $past(k_lo, 2)} > 5'h0F))
		else $error("nibble carry wrong on add");
	a_sub_borrow: assert property (
		s_lit(`RCA_L_SUB) |=> ##1 acc_out == $past(k, 2) - $past(acc_out)
		&& status_out[`RCA_ST_C] == ($past(k, 2) >= $past(acc_out))
		&& status_out[`RCA_ST_NC] == ($past(k_lo, 2) >= $past(a_lo)))
		else $error("subtract result or borrow wrong");
	a_zero_flag: assert property (
		s_ok ##0 (cls == `RCA_CL_LIT && sub >= `RCA_L_IOR &&
		sub <= `RCA_L_ADD) |=> ##1
		status_out[`RCA_ST_Z] == (acc_out == 8'h00))
		else $error("zero flag wrong");
	a_mov_lit: assert property (
		s_lit(`RCA_L_MOV) |=> ##1 acc_out == $past(k, 2) &&
		$stable(status_out))
		else $error("literal move wrong");
	a_store_file: assert property (
		s_ok ##0 (cls == `RCA_CL_FILE && sub == `RCA_F_MISC &&
		prog_data[7] && fa > 7'h04) |-> ##2 dm_we &&
		dm_waddr[6:0] == $past(fa, 2) && dm_wdata == acc_out)
		else $error("store to file wrong");
	a_no_sfr_write: assert property (
		dm_we |-> !(dm_waddr[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04}))
		else $error("internal register written outside");
	a_direct_addr: assert property (
		(cls == `RCA_CL_FILE && fa != 7'h00) |=>
		dm_raddr[6:0] == $past(fa))
		else $error("direct data address wrong");
	a_jump_target: assert property (
		s_ok ##0 (cls == `RCA_CL_JUMP) |=> ##1
		prog_addr[10:0] == $past(prog_data[10:0], 2))
		else $error("jump target not fetched");
endmodule // rca_core_properties
bind rca_core rca_core_properties u_props (.clk_sys, .rst, .prog_data,
	.prog_addr, .dm_rdata, .dm_raddr, .dm_waddr, .dm_wdata, .dm_we,
	.acc_out, .status_out);

// [tb/rca_mem_model.sv]
// Program and data memory facing the core
`timescale 1ns/1ps
module rca_mem_model (
	input wire clk_sys,
	input wire [12:0] prog_addr,
	output wire [13:0] prog_data,
	input wire [7:0] dm_raddr,
	output wire [7:0] dm_rdata,
	input wire [7:0] dm_waddr,
	input wire [7:0] dm_wdata,
	input wire dm_we
);
	reg [13:0] prog [0:8191];
	reg [7:0] dmem [0:255];
	integer wcount;
	integer n;
	// Blank words decode as no-ops, never unknown
	initial
	begin
		for (n = 0; n < 8192; n = n + 1)
			prog[n] = 14'h0000;
		wcount = 0;
	end
	assign prog_data = prog[prog_addr];
	assign dm_rdata = dmem[dm_raddr];
	always @(posedge clk_sys)
	begin
		if (dm_we)
		begin
			dmem[dm_waddr] <= dm_wdata;
			wcount <= wcount + 1;
		end
	end
endmodule // rca_mem_model

// [tb/risc_core_alu_datapath_bench.sv]
// Self-checking bench for the core and its memories
`timescale 1ns/1ps
`include "rca_regs.vh"
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) \
	begin failures = failures + 1; \
	$display("[FAIL] %0t value mismatch", $time); end end
module risc_core_alu_datapath_bench;
	reg clk_sys;
	reg rst;
	wire [13:0] prog_data;
	wire [12:0] prog_addr;
	wire [7:0] dm_rdata, dm_raddr, dm_waddr, dm_wdata, acc_out, status_out;
	wire dm_we;
	integer failures, compares, i, j;
	reg [7:0] k1, k2, d21, d22;
	reg [3:0] op;
	reg [10:0] e;
	rca_core dut (.clk_sys(clk_sys), .rst(rst), .prog_data(prog_data),
		.prog_addr(prog_addr), .dm_rdata(dm_rdata), .dm_raddr(dm_raddr),
		.dm_waddr(dm_waddr), .dm_wdata(dm_wdata), .dm_we(dm_we),
		.acc_out(acc_out), .status_out(status_out));
	rca_mem_model mem (.clk_sys(clk_sys), .prog_addr(prog_addr),
		.prog_data(prog_data), .dm_raddr(dm_raddr), .dm_rdata(dm_rdata),
		.dm_waddr(dm_waddr), .dm_wdata(dm_wdata), .dm_we(dm_we));
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function [13:0] lw(input [3:0] o, input [7:0] v);
		lw = {`RCA_CL_LIT, o, v};
	endfunction
	function [13:0] fw(input [3:0] o, input dst, input [6:0] f);
		fw = {`RCA_CL_FILE, o, dst, f};
	endfunction
	// Returns zero, nibble carry, carry and result
	function [10:0] exp_lit(input [3:0] o, input [7:0] a, input [7:0] b);
		reg [8:0] s;
		reg c;
		reg h;
		begin
			c = 1'b0;
			h = 1'b0;
			s = {1'b0, a ^ b};
			if (o == `RCA_L_IOR)
				s = {1'b0, a | b};
			if (o == `RCA_L_AND)
				s = {1'b0, a & b};
			if (o == `RCA_L_SUB)
			begin
				s = {1'b0, b - a};
				c = b >= a;
				h = b[3:0] >= a[3:0];
			end
			if (o == `RCA_L_ADD)
			begin
				s = a + b;
				c = s[8];
				h = a[3:0] + b[3:0] > 5'h0F;
			end
			exp_lit = {s[7:0] == 8'h00, h, c, s[7:0]};
		end
	endfunction
	// Fresh data memory each run so stale bytes cannot pass
	task boot;
		begin
			@(posedge clk_sys);
			#1 rst = 1'b1;
			mem.wcount = 0;
			for (j = 0; j < 256; j = j + 1)
				mem.dmem[j] = $urandom;
			repeat (4) @(posedge clk_sys);
			#1 rst = 1'b0;
			`CHK({acc_out, status_out}, 16'h0000)
		end
	endtask
	task give_verdict;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial
	begin
		rst = 1'b1;
		failures = 0;
		compares = 0;
		k1 = $urandom(32'h7B72);
		// Let the model clear its program store first
		@(posedge clk_sys);
		for (i = 0; i < 16; i = i + 1)
		begin
			k1 = $urandom;
			k2 = $urandom;
			op = 4'h2 + 4'($urandom % 5);
			if (i < 3)
				op = (i == 0) ? `RCA_L_ADD : `RCA_L_SUB;
			if (i == 0)
				{k1, k2} = 16'hFF01;
			if (i == 1)
				k2 = k1;
			if (i == 2)
				{k1, k2} = 16'h100F;
			mem.prog[0] = lw(`RCA_L_MOV, k1);
			mem.prog[1] = lw(op, k2);
			mem.prog[2] = {`RCA_CL_JUMP, 1'b1, 11'h002};
			boot;
			repeat (8) @(posedge clk_sys);
			#1 e = exp_lit(op, k1, k2);
			`CHK(acc_out, e[7:0])
			`CHK(status_out[2:0], e[10:8])
			$display("literal test %0d done", i);
		end
		for (i = 0; i < 4; i = i + 1)
		begin
			k1 = $urandom;
			mem.prog[0] = lw(`RCA_L_MOV, 8'h30);
			mem.prog[1] = fw(`RCA_F_MISC, 1'b1, 7'h04);
			mem.prog[2] = lw(`RCA_L_MOV, k1);
			mem.prog[3] = fw(`RCA_F_MISC, 1'b1, 7'h20);
			mem.prog[4] = fw(`RCA_F_ADD, 1'b1, 7'h21);
			mem.prog[5] = fw(`RCA_F_ADD, 1'b0, 7'h22);
			mem.prog[6] = fw(`RCA_F_MISC, 1'b1, 7'h00);
			mem.prog[7] = {`RCA_CL_JUMP, 1'b1, 11'h007};
			boot;
			d21 = mem.dmem[8'h21];
			d22 = mem.dmem[8'h22];
			repeat (14) @(posedge clk_sys);
			#1;
			`CHK(mem.dmem[8'h20], k1)
			`CHK(mem.dmem[8'h21], k1 + d21)
			`CHK(mem.dmem[8'h30], k1 + d22)
			`CHK(acc_out, k1 + d22)
			`CHK(mem.wcount, 3)
			$display("file test %0d done", i);
		end
		// Call, return with literal, rotate, swap; dropped prefetches
		for (i = 0; i < 2; i = i + 1)
		begin
			k1 = $urandom;
			k2 = {k1[6:0], 1'b0};
			mem.prog[0] = lw(`RCA_L_MOV, k1);
			mem.prog[1] = fw(`RCA_F_MISC, 1'b1, 7'h23);
			mem.prog[2] = fw(`RCA_F_RLC, 1'b1, 7'h23);
			mem.prog[3] = {`RCA_CL_JUMP, 1'b0, 11'h007};
			mem.prog[4] = fw(`RCA_F_MISC, 1'b1, 7'h24);
			mem.prog[5] = {`RCA_CL_JUMP, 1'b1, 11'h005};
			mem.prog[7] = fw(`RCA_F_SWAP, 1'b1, 7'h23);
			mem.prog[8] = lw(`RCA_L_RET, 8'h5A);
			mem.prog[9] = lw(`RCA_L_MOV, 8'hFF);
			boot;
			repeat (16) @(posedge clk_sys);
			#1;
			`CHK(mem.dmem[8'h23], {k2[3:0], k2[7:4]})
			`CHK(mem.dmem[8'h24], 8'h5A)
			`CHK(acc_out, 8'h5A)
			`CHK(status_out[2:0], {2'b00, k1[7]})
			`CHK(mem.wcount, 4)
			$display("flow test %0d done", i);
		end
		give_verdict;
	end
endmodule // risc_core_alu_datapath_bench
